/* recovery_consts.vh */
// Constants shared by the recovery register block, its serial port and its tick generator.
`ifndef RECOVERY_CONSTS_VH
`define RECOVERY_CONSTS_VH

// ****************************************
// Register addresses (7-bit serial address)
// ****************************************
`define ADDR_OPTIONS 7'h39
`define ADDR_CAL_HIGH 7'h3A
`define ADDR_CAL_LOW 7'h3B
`define ADDR_CTRL_ONE 7'h3C
`define ADDR_CLK_SEL 7'h3D

// ****************************************
// Reset values and read masks
// ****************************************
`define CTRL_ONE_RESET 8'h04
`define CLK_SEL_RESET 8'h00
`define OPTIONS_RESET 8'h00
`define WAKE_SEL_RESET 1'b0
`define COARSE_TRIM_RESET 5'h00
`define CAL_RESET 16'h0000
`define CTRL_ONE_MASK 8'h0D
`define CLK_SEL_MASK 8'h03
`define OPTIONS_MASK 8'h9F
`define READ_ZERO 8'h00

// ****************************************
// Field positions
// ****************************************
`define RECOVERY_ENABLE_BIT 0
`define FILTER_SEL_MSB 3
`define FILTER_SEL_LSB 2
`define CLK_SEL_MSB 1
`define CLK_SEL_LSB 0
`define WAKE_SEL_BIT 7
`define COARSE_TRIM_MSB 4
`define COARSE_TRIM_LSB 0
`define TRIM_UNLOCKED 2'h3

// ****************************************
// Filter codes and shifts
// ****************************************
`define FILT_8 2'h0
`define FILT_16 2'h1
`define FILT_32 2'h2
`define FILT_ADAPT 2'h3
`define SHIFT_8 3'h3
`define SHIFT_16 3'h4
`define SHIFT_32 3'h5

// ****************************************
// Recovery clock generation, rates in MHz
// ****************************************
`define MCLK_MHZ 9'h0FA
`define RATE_80 9'h050
`define RATE_40 9'h028
`define RATE_20 9'h014
`define RATE_10 9'h00A
`define CLK_SEL_80 2'h0
`define CLK_SEL_40 2'h1
`define CLK_SEL_20 2'h2

// ****************************************
// Serial frame and counters
// ****************************************
`define SPI_CMD_BITS 5'h08
`define SPI_FRAME_BITS 5'h10
`define GAP_MAX 12'hFFF

`endif

/* recovery_tick_gen.v */
// Phase accumulator that turns mclk into the selected recovery clock rate as single-cycle ticks.
`timescale 1ns/1ns
`default_nettype none
`include "recovery_consts.vh"

module recovery_tick_gen (
  input wire mclk,
  input wire sys_rst,
  input wire [1:0] clk_select,
  output reg tick
);

  reg [8:0] acc_q;
  wire [8:0] step;
  wire [9:0] sum;

  // Map the two-bit select onto a rate in MHz.
  function [8:0] rate_of;
    input [1:0] sel;
    begin
      case (sel)
        `CLK_SEL_80: rate_of = `RATE_80;
        `CLK_SEL_40: rate_of = `RATE_40;
        `CLK_SEL_20: rate_of = `RATE_20;
        default: rate_of = `RATE_10;
      endcase
    end
  endfunction

  assign step = rate_of(clk_select);
  assign sum = {1'b0, acc_q} + {1'b0, step};

  // 80 MHz is not a divisor of 250 MHz, so ticks carry a cycle of jitter; the average rate is exact.
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      acc_q <= 9'h000;
      tick <= 1'b0;
    end
    else if (sum >= {1'b0, `MCLK_MHZ})
    begin
      acc_q <= sum[8:0] - `MCLK_MHZ;
      tick <= 1'b1;
    end
    else
    begin
      acc_q <= sum[8:0];
      tick <= 1'b0;
    end
  end

endmodule // recovery_tick_gen
`default_nettype wire

/* spi_byte_port.v */
// Serial register port: 16-bit frames, LSB first, address byte then data byte.
`timescale 1ns/1ns
`default_nettype none
`include "recovery_consts.vh"

module spi_byte_port (
  input wire mclk,
  input wire sys_rst,
  input wire spi_csn,
  input wire spi_sck,
  input wire spi_sdi,
  input wire [7:0] rdata,
  output reg spi_sdo,
  output reg spi_sdo_en,
  output reg [6:0] addr,
  output reg wr_pulse,
  output reg [7:0] wdata
);

  reg [2:0] csn_s;
  reg [2:0] sck_s;
  reg [2:0] sdi_s;
  reg csn_l;
  reg sck_l;
  reg [15:0] shift_q;
  reg [7:0] tx_q;
  reg [4:0] cnt_q;
  reg load_q;
  wire [15:0] shift_d;
  wire sck_rise;
  wire sck_fall;

  // A clock or select level is accepted only once the second and third stages agree.
  assign sck_rise = (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_l;
  assign sck_fall = (sck_s[1] == sck_s[2]) && !sck_s[2] && sck_l;
  assign shift_d = {sdi_s[2], shift_q[15:1]};

  // ****************************************
  // Pin synchronisers and frame sequencing
  // ****************************************
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      csn_s <= 3'h7;
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
      csn_l <= 1'b1;
      sck_l <= 1'b0;
      shift_q <= 16'h0000;
      tx_q <= 8'h00;
      cnt_q <= 5'h00;
      load_q <= 1'b0;
      spi_sdo <= 1'b0;
      spi_sdo_en <= 1'b0;
      addr <= 7'h00;
      wr_pulse <= 1'b0;
      wdata <= 8'h00;
    end
    else
    begin
      csn_s <= {csn_s[1:0], spi_csn};
      sck_s <= {sck_s[1:0], spi_sck};
      sdi_s <= {sdi_s[1:0], spi_sdi};
      wr_pulse <= 1'b0;
      load_q <= 1'b0;
      if (sck_s[1] == sck_s[2])
        sck_l <= sck_s[2];
      if (load_q)
        tx_q <= rdata; // Read data is fetched one cycle after the address settles.
      if ((csn_s[1] == csn_s[2]) && (csn_s[2] != csn_l))
      begin
        csn_l <= csn_s[2];
        if (!csn_s[2])
        begin
          cnt_q <= 5'h00;
          spi_sdo <= 1'b0;
          spi_sdo_en <= 1'b1;
        end
        else
        begin
          spi_sdo_en <= 1'b0;
          // Only a complete frame with the write flag set commits data.
          if ((cnt_q == `SPI_FRAME_BITS) && shift_q[7])
          begin
            wr_pulse <= 1'b1;
            wdata <= shift_q[15:8];
          end
        end
      end
      else if (!csn_l && sck_rise && (cnt_q != `SPI_FRAME_BITS))
      begin
        shift_q <= shift_d;
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == (`SPI_CMD_BITS - 5'h01))
        begin
          addr <= shift_d[14:8];
          load_q <= 1'b1;
        end
      end
      else if (!csn_l && sck_fall && (cnt_q >= `SPI_CMD_BITS))
      begin
        spi_sdo <= tx_q[0];
        tx_q <= {1'b0, tx_q[7:1]};
      end
    end
  end

endmodule // spi_byte_port
`default_nettype wire

/* wake_recovery_regs.v */
// Clock-and-data recovery registers and bit-time tracking for the selective-wake frame detector.
`timescale 1ns/1ns
`default_nettype none
`include "recovery_consts.vh"

module wake_recovery_regs (
  input wire mclk,
  input wire sys_rst,
  input wire spi_csn,
  input wire spi_sck,
  input wire spi_sdi,
  output wire spi_sdo,
  output wire spi_sdo_en,
  input wire [1:0] trim_unlock,
  input wire rx_standard,
  input wire rx_low_power,
  input wire [7:0] bit_time_length,
  input wire [7:0] upper_bit_time_limit,
  input wire [7:0] lower_bit_time_limit,
  output reg wake_receiver_select,
  output reg [4:0] coarse_trim,
  output reg recovery_enable,
  output reg [2:0] filter_shift,
  output reg [15:0] bit_time_estimate
);

  // ****************************************
  // Declarations
  // ****************************************
  reg [7:0] ctrl_one_q;
  reg [7:0] clk_sel_q;
  reg [15:0] cal_q;
  reg [2:0] rx_s;
  reg rx_l;
  reg seen_edge_q;
  reg [11:0] gap_q;
  reg [7:0] rdata;
  reg [2:0] shift_d;
  reg [2:0] held_shift_q;
  reg [11:0] per_bit;
  reg accept;
  reg [7:0] sample;
  wire [6:0] addr;
  wire wr_pulse;
  wire [7:0] wdata;
  wire tick;
  wire rx_pick;
  wire fall;
  wire [12:0] gap2;
  wire signed [16:0] diff;
  wire signed [16:0] step;

  // ****************************************
  // Helpers
  // ****************************************

  // Bit length times k, used against twice the gap so half-bit bounds stay integral.
  function [12:0] times_k;
    input [7:0] b;
    input [4:0] k;
    begin
      times_k = {5'h00, b} * {8'h00, k};
    end
  endfunction

  // Fixed filter code to right-shift amount.
  function [2:0] shift_of;
    input [1:0] code;
    begin
      case (code)
        `FILT_8: shift_of = `SHIFT_8;
        `FILT_32: shift_of = `SHIFT_32;
        default: shift_of = `SHIFT_16;
      endcase
    end
  endfunction

  // ****************************************
  // Register port and recovery clock
  // ****************************************
  spi_byte_port u_port (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .spi_csn(spi_csn),
    .spi_sck(spi_sck),
    .spi_sdi(spi_sdi),
    .rdata(rdata),
    .spi_sdo(spi_sdo),
    .spi_sdo_en(spi_sdo_en),
    .addr(addr),
    .wr_pulse(wr_pulse),
    .wdata(wdata)
  );

  recovery_tick_gen u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_select(clk_sel_q[`CLK_SEL_MSB:`CLK_SEL_LSB]),
    .tick(tick)
  );

  // ****************************************
  // Read multiplexer
  // ****************************************

  // Stored values are masked on the way out so reserved bits can never leak.
  always @*
  begin
    case (addr)
      `ADDR_OPTIONS: rdata = {wake_receiver_select, 2'b00, coarse_trim};
      `ADDR_CAL_HIGH: rdata = cal_q[15:8];
      `ADDR_CAL_LOW: rdata = cal_q[7:0];
      `ADDR_CTRL_ONE: rdata = ctrl_one_q & `CTRL_ONE_MASK;
      `ADDR_CLK_SEL: rdata = clk_sel_q & `CLK_SEL_MASK;
      default: rdata = `READ_ZERO;
    endcase
  end

  // ****************************************
  // Register writes
  // ****************************************

  // Calibration bytes have no write path at all; the trim byte is locked unless unlocked by the trim field.
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_one_q <= `CTRL_ONE_RESET;
      clk_sel_q <= `CLK_SEL_RESET;
      wake_receiver_select <= `WAKE_SEL_RESET;
      coarse_trim <= `COARSE_TRIM_RESET;
      recovery_enable <= 1'b0;
      filter_shift <= `SHIFT_16;
    end
    else
    begin
      recovery_enable <= ctrl_one_q[`RECOVERY_ENABLE_BIT];
      // A fixed code shows at once; adaptive mode shows the constant taken at the last falling edge.
      if (ctrl_one_q[`FILTER_SEL_MSB:`FILTER_SEL_LSB] == `FILT_ADAPT)
        filter_shift <= held_shift_q;
      else
        filter_shift <= shift_d;
      // Writes land one cycle after the port's commit pulse, which follows the chip-select rise.
      if (wr_pulse)
      begin
        case (addr)
          `ADDR_CTRL_ONE: ctrl_one_q <= wdata & `CTRL_ONE_MASK;
          `ADDR_CLK_SEL: clk_sel_q <= wdata & `CLK_SEL_MASK;
          `ADDR_OPTIONS:
          begin
            if (trim_unlock == `TRIM_UNLOCKED)
            begin
              wake_receiver_select <= wdata[`WAKE_SEL_BIT];
              coarse_trim <= wdata[`COARSE_TRIM_MSB:`COARSE_TRIM_LSB];
            end
          end
          default: ctrl_one_q <= ctrl_one_q;
        endcase
      end
    end
  end

  // ****************************************
  // Receiver selection and edge detection
  // ****************************************
  // Switching receivers while recovery runs may show one false edge, so select before enabling.
  assign rx_pick = wake_receiver_select ? rx_low_power : rx_standard;
  assign fall = (rx_s[1] == rx_s[2]) && !rx_s[2] && rx_l;
  assign gap2 = {gap_q, 1'b0};

  // The bus level is accepted only once two synchroniser stages agree, which also rejects short glitches.
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rx_s <= 3'h7;
      rx_l <= 1'b1;
    end
    else
    begin
      rx_s <= {rx_s[1:0], rx_pick};
      if (rx_s[1] == rx_s[2])
        rx_l <= rx_s[2];
    end
  end

  // ****************************************
  // Spacing classification and sample
  // ****************************************

  // Only spacings near 2, 4 or 8 bits give a per-bit time by a plain shift, so others are not sampled.
  always @*
  begin
    per_bit = gap_q;
    accept = 1'b0;
    if ((gap2 >= times_k(bit_time_length, 5'h03)) && (gap2 < times_k(bit_time_length, 5'h05)))
    begin
      per_bit = {1'b0, gap_q[11:1]};
      accept = 1'b1;
    end
    else if ((gap2 >= times_k(bit_time_length, 5'h07)) && (gap2 < times_k(bit_time_length, 5'h09)))
    begin
      per_bit = {2'b00, gap_q[11:2]};
      accept = 1'b1;
    end
    else if ((gap2 >= times_k(bit_time_length, 5'h0F)) && (gap2 < times_k(bit_time_length, 5'h11)))
    begin
      per_bit = {3'b000, gap_q[11:3]};
      accept = 1'b1;
    end
    // Clamp to the programmed window before filtering.
    if (per_bit > {4'h0, upper_bit_time_limit})
      sample = upper_bit_time_limit;
    else if (per_bit < {4'h0, lower_bit_time_limit})
      sample = lower_bit_time_limit;
    else
      sample = per_bit[7:0];
    // Adaptive mode picks the constant from how far apart the falling edges were.
    if (ctrl_one_q[`FILTER_SEL_MSB:`FILTER_SEL_LSB] != `FILT_ADAPT)
      shift_d = shift_of(ctrl_one_q[`FILTER_SEL_MSB:`FILTER_SEL_LSB]);
    else if (gap2 < times_k(bit_time_length, 5'h07))
      shift_d = `SHIFT_32;
    else if (gap2 < times_k(bit_time_length, 5'h11))
      shift_d = `SHIFT_16;
    else
      shift_d = `SHIFT_8;
  end

  // ****************************************
  // Adaptive constant hold
  // ****************************************

  // The live choice follows the running gap, so the constant shown is the one taken at the last edge.
  always @(posedge mclk)
  begin
    if (sys_rst)
      held_shift_q <= `SHIFT_16;
    else if (!ctrl_one_q[`RECOVERY_ENABLE_BIT])
      held_shift_q <= `SHIFT_16;
    else if (fall)
      held_shift_q <= shift_d;
  end

  // ****************************************
  // Bit-time measurement and filter
  // ****************************************
  // The step uses the gap that ends at this edge, so a new spacing acts on its own sample.
  // Negative steps round towards minus infinity, so the estimate settles exactly on a lower target, never above it.
  assign diff = $signed({1'b0, sample, 8'h00}) - $signed({1'b0, cal_q});
  assign step = diff >>> shift_d;

  // The estimate is 8.8 fixed point; its high byte is the whole bit time and shows in the calibration bytes.
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      gap_q <= 12'h000;
      seen_edge_q <= 1'b0;
      cal_q <= `CAL_RESET;
      bit_time_estimate <= `CAL_RESET;
    end
    else
    begin
      bit_time_estimate <= cal_q;
      if (!ctrl_one_q[`RECOVERY_ENABLE_BIT])
      begin
        gap_q <= 12'h000;
        seen_edge_q <= 1'b0;
      end
      else if (fall)
      begin
        seen_edge_q <= 1'b1;
        gap_q <= 12'h000;
        if (seen_edge_q && accept)
          cal_q <= cal_q + step[15:0];
      end
      else if (tick && (gap_q != `GAP_MAX))
        gap_q <= gap_q + 12'h001;
    end
  end

endmodule // wake_recovery_regs
`default_nettype wire

/* recovery_checker.sv */
// Port-level checks on the wake recovery register block.
`timescale 1ns/1ns
`default_nettype none
module recovery_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spi_csn,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_en,
  input wire logic [1:0] trim_unlock,
  input wire logic rx_standard,
  input wire logic rx_low_power,
  input wire logic [7:0] bit_time_length,
  input wire logic [7:0] upper_bit_time_limit,
  input wire logic [7:0] lower_bit_time_limit,
  input wire logic wake_receiver_select,
  input wire logic [4:0] coarse_trim,
  input wire logic recovery_enable,
  input wire logic [2:0] filter_shift,
  input wire logic [15:0] bit_time_estimate
);
  // ********
  // Checks
  // ********
  // One clock domain, so every check shares the clock and the reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Outputs leave reset at their defaults.
  reset_values_a: assert property ($fell(sys_rst) |-> filter_shift == 3'h4 && !recovery_enable
    && !wake_receiver_select && coarse_trim == 5'h00 && bit_time_estimate == 16'h0000)
    else $error("outputs not at reset values");
  // Synchroniser depth is four cycles, so six cycles of a steady select must show.
  enable_on_a: assert property (!spi_csn [*6] |-> spi_sdo_en) else $error("sdo enable missing in frame");
  enable_off_a: assert property (spi_csn [*6] |-> !spi_sdo_en) else $error("sdo enable outside frame");
  // The receiver choice and coarse trim move only while unlocked.
  select_locked_a: assert property ($changed(wake_receiver_select) |-> $past(trim_unlock, 1) == 2'h3)
    else $error("receiver select changed while locked");
  trim_locked_a: assert property ($changed(coarse_trim) |-> $past(trim_unlock, 1) == 2'h3)
    else $error("coarse trim changed while locked");
  // The enable bit only follows a completed frame.
  enable_commit_a: assert property ($changed(recovery_enable) |-> spi_csn && !$past(spi_csn, 8))
    else $error("recovery enable changed outside a commit");
  // Only the three filter constants exist.
  shift_range_a: assert property (filter_shift >= 3'h3 && filter_shift <= 3'h5)
    else $error("filter shift out of range");
  // A stopped recovery unit must not move the estimate.
  estimate_hold_a: assert property (!recovery_enable [*4] |=> $stable(bit_time_estimate))
    else $error("estimate moved while recovery off");
  // Read data only moves after a clock fall.
  sdo_steady_a: assert property (spi_sck [*6] |-> $stable(spi_sdo)) else $error("sdo moved while sck high");
endmodule // recovery_checker
bind wake_recovery_regs recovery_checker recovery_checker_inst (.*);
`default_nettype wire

/* can_traffic.sv */
// Bus model: wake receiver outputs carrying dominant bits at a fixed spacing.
`timescale 1ns/1ns
`default_nettype none
module can_traffic (
  input wire logic run,
  input wire logic on_low_power,
  input wire logic [3:0] gap_bits,
  output logic rx_standard,
  output logic rx_low_power
);
  // ********
  // Traffic
  // ********
  // A bit lasts 2000 ns, which is 500 kbit/s.
  localparam int BIT_NS = 2000;
  logic line;
  // One dominant bit, then recessive, so falling edges sit gap_bits apart.
  initial
  begin
    line = 1'b1;
    forever
    begin
      wait (run);
      line = 1'b0;
      #(BIT_NS);
      line = 1'b1;
      #(BIT_NS * (gap_bits - 4'h1));
    end
  end
  // The idle receiver rests recessive, as a real one would.
  assign rx_low_power = on_low_power ? line : 1'b1;
  assign rx_standard = on_low_power ? 1'b1 : line;
endmodule // can_traffic
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the wake recovery register block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk, sys_rst, spi_csn, spi_sck, spi_sdi, spi_sdo, spi_sdo_en, rx_standard, rx_low_power;
  logic wake_receiver_select, recovery_enable, run, on_low_power;
  logic [1:0] trim_unlock;
  logic [3:0] gap_bits;
  logic [4:0] coarse_trim;
  logic [2:0] filter_shift;
  logic [7:0] bit_time_length, upper_bit_time_limit, lower_bit_time_limit, rd_data;
  logic [15:0] bit_time_estimate;
  logic [6:0] addr_t [5] = '{7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D};
  logic [7:0] dflt_t [5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
  logic [3:0] gap_t [3] = '{4'h2, 4'h4, 4'h9};
  int bad_count = 0;
  int cmp_count = 0;
  wake_recovery_regs wake_recovery_regs_inst (.*);
  can_traffic can_traffic_inst (.*);
  // ********
  // Tasks
  // ********
  // A 250 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Case equality so an unknown never passes for a match.
  task automatic check(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h, wanted %h to %h", $time, got, lo, hi);
    end
  endtask
  // Serial frame, LSB first; phases of 10 cycles leave room for the synchronisers.
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d, input int n);
    logic [15:0] f;
    f = {d, w, a};
    spi_csn = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      spi_sdi = f[k];
      repeat (10) @(negedge mclk);
      if (k > 7)
        rd_data[k - 8] = spi_sdo;
      spi_sck = 1'b1;
      repeat (10) @(negedge mclk);
      spi_sck = 1'b0;
    end
    repeat (10) @(negedge mclk);
    spi_csn = 1'b1;
    repeat (12) @(negedge mclk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d, 16);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] lo, input logic [15:0] hi);
    xfer(a, 1'b0, 8'h00, 16);
    check({8'h00, rd_data}, lo, hi);
  endtask
  // Waits on bus edges, then lets the pipeline settle.
  task automatic edges(input int n);
    repeat (n) @(negedge rx_low_power);
    repeat (8) @(negedge mclk);
  endtask
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // The tests need about 85k cycles, so 100k cycles means a hang.
  initial
  begin
    #400000;
    bad_count++;
    stop_test();
  end
  // Main sequence, driven at the falling clock edge.
  initial
  begin
    {sys_rst, spi_csn, spi_sck, spi_sdi, run, on_low_power} = 6'h30;
    {trim_unlock, gap_bits} = 6'h02;
    {bit_time_length, upper_bit_time_limit, lower_bit_time_limit} = 24'hA0A898;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    for (int j = 0; j < 5; j++)
      rd(addr_t[j], dflt_t[j], dflt_t[j]);
    rd(7'h10, 16'h0000, 16'h0000);
    wr(7'h3A, 8'hFF);
    wr(7'h3B, 8'hFF);
    rd(7'h3A, 16'h0000, 16'h0000);
    rd(7'h3B, 16'h0000, 16'h0000);
    wr(7'h3C, 8'hFF);
    rd(7'h3C, 16'h000D, 16'h000D);
    check(recovery_enable, 16'h0001, 16'h0001);
    for (int c = 0; c < 3; c++)
    begin
      wr(7'h3C, 8'(c * 4));
      check({recovery_enable, filter_shift}, 3 + c, 3 + c);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(7'h3D, 8'hFC | 8'(s));
      rd(7'h3D, s, s);
    end
    // A frame one bit short must not commit.
    xfer(7'h3D, 1'b1, 8'h00, 15);
    rd(7'h3D, 16'h0003, 16'h0003);
    wr(7'h3D, 8'h00);
    wr(7'h39, 8'hFF);
    rd(7'h39, 16'h0000, 16'h0000);
    // Traffic on the unselected receiver must not be measured.
    wr(7'h3C, 8'h01);
    {run, on_low_power} = 2'b11;
    edges(4);
    check(bit_time_estimate, 16'h0000, 16'h0000);
    trim_unlock = 2'h3;
    wr(7'h39, 8'hFF);
    rd(7'h39, 16'h009F, 16'h009F);
    check({wake_receiver_select, coarse_trim}, 16'h003F, 16'h003F);
    trim_unlock = 2'h0;
    wr(7'h39, 8'h1F);
    rd(7'h39, 16'h009F, 16'h009F);
    // Two-bit spacing at 80 MHz gives 160 ticks a bit.
    edges(20);
    rd(7'h3A, 16'h0090, 16'h00A0);
    {upper_bit_time_limit, lower_bit_time_limit} = 16'h9088;
    edges(20);
    rd(7'h3A, 16'h0090, 16'h0091);
    wr(7'h3C, 8'h0D);
    // Spacings of 2, 4 and 9 bits fall in the three adaptive bands.
    for (int g = 0; g < 3; g++)
    begin
      gap_bits = gap_t[g];
      edges(3);
      check(filter_shift, 5 - g, 5 - g);
    end
    // At 40 MHz a four-bit spacing measures as two nominal bits, so adaptive mode picks 32.
    gap_bits = 4'h4;
    wr(7'h3D, 8'h01);
    edges(3);
    check(filter_shift, 16'h0005, 16'h0005);
    // A soft reset in mid-run must bring every register back to its default.
    sys_rst = 1'b1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    for (int j = 0; j < 5; j++)
      rd(addr_t[j], dflt_t[j], dflt_t[j]);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
